// file: verilog/ctotb_pkg.sv
// Purpose: Constants and carriers for the core timing/offset trim bank
// Assumes: APB slave with 32-bit data, one register per aligned word
// Notes: Printed offsets are not all multiples of four, so they are indices
package ctotb_pkg;
	// ****************************************
	// Register indices (byte address = 4 * index)
	// ****************************************
	localparam logic [11:0] IDX_B_S_IN1_DLY = 12'h315;
	localparam logic [11:0] IDX_A_S_IN2_DLY = 12'h31a;
	localparam logic [11:0] IDX_B_S_IN2_DLY = 12'h31b;
	localparam logic [11:0] IDX_A_D_IN1_OFS = 12'h344;
	localparam logic [11:0] IDX_A_D_IN2_OFS = 12'h346;
	localparam logic [11:0] IDX_A_S_IN1_OFS = 12'h348;
	localparam int ADDR_LSB = 2;
	localparam int ADDR_W = 14;

	// ****************************************
	// Field layout and reset values
	// ****************************************
	localparam int DLY_W = 8;
	localparam int OFS_W = 12;
	localparam int OFS_REG_W = 16;
	localparam logic [DLY_W-1:0] DLY_NOMINAL = 8'h00;
	localparam logic [OFS_REG_W-1:0] OFS_NOMINAL = 16'h0000;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [DLY_W-1:0] b_s_in1;
		logic [DLY_W-1:0] a_s_in2;
		logic [DLY_W-1:0] b_s_in2;
	} ctotb_dly_t;

	typedef struct packed {
		logic [OFS_REG_W-1:0] a_d_in1;
		logic [OFS_REG_W-1:0] a_d_in2;
		logic [OFS_REG_W-1:0] a_s_in1;
	} ctotb_ofs_t;

	typedef struct packed {
		logic single_mode;
		logic second_input;
		logic fg_cal_en;
	} ctotb_mode_t;
endpackage

// file: verilog/ctotb_bank.sv
// Purpose: APB-reachable trim bank steering core timing and offset trims
// Assumes: Fuse values valid while fuse_valid_i is high after reset
// Notes: Trim outputs update only on conv_start_i so a conversion sees one value
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
module ctotb_bank (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ctotb_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire ctotb_pkg::ctotb_dly_t fuse_dly_i,
	input wire ctotb_pkg::ctotb_ofs_t fuse_ofs_i,
	input wire logic fuse_valid_i,
	input wire ctotb_pkg::ctotb_mode_t mode_i,
	input wire logic conv_start_i,
	output logic [ctotb_pkg::DLY_W-1:0] acore_delay_o,
	output logic [ctotb_pkg::DLY_W-1:0] bcore_delay_o,
	output logic [ctotb_pkg::OFS_W-1:0] acore_offset_o,
	output logic acore_delay_en_o,
	output logic bcore_delay_en_o,
	output logic acore_offset_en_o
);
	// ****************************************
	// Register storage
	// ****************************************
	ctotb_pkg::ctotb_dly_t dly;
	ctotb_pkg::ctotb_ofs_t ofs;
	logic fuse_loaded;
	logic bus_ready;

	function automatic logic hit(input logic [11:0] idx,
		input logic [11:0] target);
		hit = (idx == target);
	endfunction

	// ****************************************
	// APB decode
	// ****************************************
	wire logic [11:0] idx = paddr_i[ctotb_pkg::ADDR_W-1:ctotb_pkg::ADDR_LSB];
	wire logic access = psel_i & penable_i;
	wire logic wr = access & pwrite_i;
	wire logic h_b1d = hit(idx, ctotb_pkg::IDX_B_S_IN1_DLY);
	wire logic h_a2d = hit(idx, ctotb_pkg::IDX_A_S_IN2_DLY);
	wire logic h_b2d = hit(idx, ctotb_pkg::IDX_B_S_IN2_DLY);
	wire logic h_a1o = hit(idx, ctotb_pkg::IDX_A_D_IN1_OFS);
	wire logic h_a2o = hit(idx, ctotb_pkg::IDX_A_D_IN2_OFS);
	wire logic h_s1o = hit(idx, ctotb_pkg::IDX_A_S_IN1_OFS);
	wire logic mapped = h_b1d | h_a2d | h_b2d | h_a1o | h_a2o | h_s1o;
	// Writes before fuse load would be lost, so hold the bus off
	// One cycle after load, so read data is never pre-load
	assign pready_o = bus_ready;
	assign pslverr_o = access & bus_ready & ~mapped;
	wire logic wr_ok = wr & bus_ready & mapped;

	wire logic [31:0] rd_mux =
		h_b1d ? {24'h000000, dly.b_s_in1} :
		h_a2d ? {24'h000000, dly.a_s_in2} :
		h_b2d ? {24'h000000, dly.b_s_in2} :
		h_a1o ? {16'h0000, ofs.a_d_in1} :
		h_a2o ? {16'h0000, ofs.a_d_in2} :
		h_s1o ? {16'h0000, ofs.a_s_in1} : ctotb_pkg::RD_ZERO;

	function automatic logic [7:0] lane(input logic [7:0] old,
		input logic [7:0] nw, input logic en);
		lane = en ? nw : old;
	endfunction

	function automatic logic [15:0] ofs_wr(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] st);
		ofs_wr = {lane(old[15:8], wd[15:8], st[1]),
			lane(old[7:0], wd[7:0], st[0])};
	endfunction

	// ****************************************
	// Fuse load and software writes
	// ****************************************
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dly <= {3{ctotb_pkg::DLY_NOMINAL}};
			ofs <= {3{ctotb_pkg::OFS_NOMINAL}};
			fuse_loaded <= 1'b0;
		end else if (!fuse_loaded) begin
			if (fuse_valid_i) begin
				dly <= fuse_dly_i;
				ofs <= fuse_ofs_i;
				fuse_loaded <= 1'b1;
			end
		end else if (wr_ok) begin
			if (h_b1d)
				dly.b_s_in1 <= lane(dly.b_s_in1, pwdata_i[7:0], pstrb_i[0]);
			if (h_a2d)
				dly.a_s_in2 <= lane(dly.a_s_in2, pwdata_i[7:0], pstrb_i[0]);
			if (h_b2d)
				dly.b_s_in2 <= lane(dly.b_s_in2, pwdata_i[7:0], pstrb_i[0]);
			if (h_a1o)
				ofs.a_d_in1 <= ofs_wr(ofs.a_d_in1, pwdata_i, pstrb_i);
			if (h_a2o)
				ofs.a_d_in2 <= ofs_wr(ofs.a_d_in2, pwdata_i, pstrb_i);
			if (h_s1o)
				ofs.a_s_in1 <= ofs_wr(ofs.a_s_in1, pwdata_i, pstrb_i);
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i)
			prdata_o <= ctotb_pkg::RD_ZERO;
		else if (psel_i & ~pwrite_i & ~(penable_i & bus_ready))
			prdata_o <= rd_mux;
	end

	// ****************************************
	// Bus ready
	// ****************************************
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i)
			bus_ready <= 1'b0;
		else
			bus_ready <= fuse_loaded;
	end

	// ****************************************
	// Trim selection
	// ****************************************
	wire logic sel_s = mode_i.single_mode & mode_i.fg_cal_en;
	wire logic sel_d = ~mode_i.single_mode & mode_i.fg_cal_en;
	wire logic in2 = mode_i.second_input;
	wire logic next_a_dly_en = sel_s & in2;
	wire logic next_b_dly_en = sel_s;
	wire logic [7:0] next_a_dly = next_a_dly_en ? dly.a_s_in2 : 8'h00;
	wire logic [7:0] next_b_dly = ~sel_s ? 8'h00 :
		in2 ? dly.b_s_in2 : dly.b_s_in1;
	wire logic next_a_ofs_en = sel_d | (sel_s & ~in2);
	wire logic [11:0] next_a_ofs =
		(sel_s & ~in2) ? ofs.a_s_in1[11:0] :
		(sel_d & in2) ? ofs.a_d_in2[11:0] :
		sel_d ? ofs.a_d_in1[11:0] : 12'h000;

	// Sampled per conversion so a write mid-conversion does not glitch
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acore_delay_o <= ctotb_pkg::DLY_NOMINAL;
			bcore_delay_o <= ctotb_pkg::DLY_NOMINAL;
			acore_offset_o <= 12'h000;
			acore_delay_en_o <= 1'b0;
			bcore_delay_en_o <= 1'b0;
			acore_offset_en_o <= 1'b0;
		end else if (conv_start_i) begin
			acore_delay_o <= next_a_dly;
			bcore_delay_o <= next_b_dly;
			acore_offset_o <= next_a_ofs;
			acore_delay_en_o <= next_a_dly_en;
			bcore_delay_en_o <= next_b_dly_en;
			acore_offset_en_o <= next_a_ofs_en;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_fuse_load_val: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(!fuse_loaded && fuse_valid_i) |=> dly == $past(fuse_dly_i))
		else $error("fuse delay trims not loaded");
	a_ofs_fuse_val: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(!fuse_loaded && fuse_valid_i) |=> ofs == $past(fuse_ofs_i))
		else $error("fuse offset trims not loaded");
	a_b1_delay_wr: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(wr_ok && h_b1d && pstrb_i[0]) |=> dly.b_s_in1 == $past(pwdata_i[7:0]))
		else $error("delay trim write lost");
	a_a2_delay_wr: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(wr_ok && h_a2d && pstrb_i[0]) |=> dly.a_s_in2 == $past(pwdata_i[7:0]))
		else $error("delay trim write lost");
	a_b2_delay_sel: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(conv_start_i && sel_s && in2) |=> bcore_delay_o == $past(dly.b_s_in2))
		else $error("wrong second core delay trim");
	a_dual_in1_ofs: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(conv_start_i && sel_d && !in2)
		|=> acore_offset_o == $past(ofs.a_d_in1[11:0]))
		else $error("wrong dual first-input offset");
	a_dual_in2_ofs: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(conv_start_i && sel_d && in2)
		|=> acore_offset_o == $past(ofs.a_d_in2[11:0]))
		else $error("wrong dual second-input offset");
	a_single_in1_ofs: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(conv_start_i && sel_s && !in2)
		|=> acore_offset_o == $past(ofs.a_s_in1[11:0]))
		else $error("wrong single first-input offset");
	a_hold_no_conv: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!conv_start_i |=> $stable(acore_offset_o) && $stable(bcore_delay_o))
		else $error("trim output changed mid conversion");
	a_b1_delay_sel: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(conv_start_i && sel_s && !in2)
		|=> bcore_delay_o == $past(dly.b_s_in1))
		else $error("wrong second core first-input delay");
	a_a2_delay_sel: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(conv_start_i && sel_s && in2)
		|=> acore_delay_o == $past(dly.a_s_in2))
		else $error("wrong first core delay trim");
	a_b2_delay_wr: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(wr_ok && h_b2d && pstrb_i[0])
		|=> dly.b_s_in2 == $past(pwdata_i[7:0]))
		else $error("delay trim write lost");
	a_d1_ofs_wr: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(wr_ok && h_a1o && pstrb_i[1:0] == 2'b11)
		|=> ofs.a_d_in1 == $past(pwdata_i[15:0]))
		else $error("offset trim write lost");
	a_d2_ofs_wr: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(wr_ok && h_a2o && pstrb_i[1:0] == 2'b11)
		|=> ofs.a_d_in2 == $past(pwdata_i[15:0]))
		else $error("offset trim write lost");
	a_s1_ofs_wr: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(wr_ok && h_s1o && pstrb_i[1:0] == 2'b11)
		|=> ofs.a_s_in1 == $past(pwdata_i[15:0]))
		else $error("offset trim write lost");
	a_a_delay_idle: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(conv_start_i && !(sel_s && in2))
		|=> acore_delay_o == 8'h00 && !acore_delay_en_o)
		else $error("first core delay active when unused");
	a_b_delay_idle: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(conv_start_i && !sel_s)
		|=> bcore_delay_o == 8'h00 && !bcore_delay_en_o)
		else $error("second core delay active when unused");
	a_ofs_idle: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(conv_start_i && !mode_i.fg_cal_en)
		|=> acore_offset_o == 12'h000 && !acore_offset_en_o)
		else $error("offset active without calibration");
	a_rd_capture: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(psel_i && !pwrite_i && !(penable_i && bus_ready))
		|=> prdata_o == $past(rd_mux))
		else $error("read data not captured");
	a_unmapped_err: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(access && bus_ready && !mapped) |-> pslverr_o)
		else $error("unmapped access not flagged");
	a_no_early_wr: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(!fuse_loaded && !fuse_valid_i)
		|=> $stable(dly) && $stable(ofs))
		else $error("trims changed before fuse load");
	a_ready_wait: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!fuse_loaded |-> !pready_o)
		else $error("bus ready before fuse load");
	a_ready_rise: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		fuse_loaded |=> pready_o)
		else $error("bus not ready after fuse load");
	a_hold_enables: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!conv_start_i |=> $stable(acore_delay_en_o)
		&& $stable(bcore_delay_en_o) && $stable(acore_offset_en_o)
		&& $stable(acore_delay_o))
		else $error("trim enable changed mid conversion");
	a_unmapped_no_wr: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(access && fuse_loaded && !mapped)
		|=> $stable(dly) && $stable(ofs))
		else $error("unmapped write changed a trim");
	a_single_ofs_en: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(conv_start_i && sel_s && !in2) |=> acore_offset_en_o)
		else $error("single offset not enabled");
	a_rd_upper_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		prdata_o[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	a_single_b_en: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(conv_start_i && sel_s) |=> bcore_delay_en_o)
		else $error("second core delay not enabled");
	a_dual_dly_off: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(conv_start_i && sel_d)
		|=> !acore_delay_en_o && !bcore_delay_en_o)
		else $error("delay trim enabled in dual mode");
	a_strb_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(wr_ok && h_b1d && !pstrb_i[0]) |=> $stable(dly.b_s_in1))
		else $error("masked byte written");
	a_dual_ofs_en: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(conv_start_i && sel_d) |=> acore_offset_en_o)
		else $error("dual offset not enabled");
endmodule

// file: dv/core_timing_offset_trim_bank_test.sv
// Purpose: Self-checking bench for the core trim bank
// Assumes: Zero-wait APB once fuse values are loaded
// Notes: Random trims, full sweep of mode, input and calibration
`timescale 1ns/100ps
module core_timing_offset_trim_bank_test;
	// ****************************************
	// Stimulus, expectations and checks
	// ****************************************
	localparam logic [11:0] IDX [6] = '{ctotb_pkg::IDX_B_S_IN1_DLY,
		ctotb_pkg::IDX_A_S_IN2_DLY, ctotb_pkg::IDX_B_S_IN2_DLY,
		ctotb_pkg::IDX_A_D_IN1_OFS, ctotb_pkg::IDX_A_D_IN2_OFS,
		ctotb_pkg::IDX_A_S_IN1_OFS};
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic fv = 1'b0;
	logic conv = 1'b0;
	logic [13:0] pa = '0;
	logic [31:0] pwd = '0;
	logic [31:0] rd, d;
	logic err, aen, ben, oen;
	logic [2:0] mode = '0;
	logic [15:0] rv [6];
	logic [7:0] ad, bd;
	logic [11:0] ao;
	logic [31:0] prdata_o;
	logic pready_o, pslverr_o, acore_delay_en_o, bcore_delay_en_o;
	logic acore_offset_en_o;
	logic [7:0] acore_delay_o, bcore_delay_o;
	logic [11:0] acore_offset_o;
	int fails = 0;
	int samples_checked = 0;
	int n;

	always #2 clock_i = ~clock_i;

	ctotb_bank u_ctotb_bank (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa),
		.pwdata_i(pwd), .pstrb_i(4'hf), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o),
		.fuse_dly_i({rv[0][7:0], rv[1][7:0], rv[2][7:0]}),
		.fuse_ofs_i({rv[3], rv[4], rv[5]}), .fuse_valid_i(fv),
		.mode_i(mode), .conv_start_i(conv), .acore_delay_o(acore_delay_o),
		.bcore_delay_o(bcore_delay_o), .acore_offset_o(acore_offset_o),
		.acore_delay_en_o(acore_delay_en_o),
		.bcore_delay_en_o(bcore_delay_en_o),
		.acore_offset_en_o(acore_offset_en_o));

	task chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			fails++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask

	// Request held until the edge that sees pready high
	task apb(input logic w, input logic [11:0] i, input logic [31:0] wd);
		@(posedge clock_i);
		psel <= 1'b1;
		pwr <= w;
		pa <= {i, 2'b00};
		pwd <= wd;
		@(posedge clock_i);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (pready_o !== 1'b1 && n < 100);
		if (n >= 100)
			fails++;
		rd = prdata_o;
		err = pslverr_o;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	function automatic void calc(input logic s, input logic b, input logic f);
		ben = s & f;
		aen = ben & b;
		oen = f & !(s & b);
		ad = aen ? rv[1][7:0] : 8'h00;
		bd = !ben ? 8'h00 : b ? rv[2][7:0] : rv[0][7:0];
		ao = !oen ? 12'h000 : s ? rv[5][11:0] : b ? rv[4][11:0] : rv[3][11:0];
	endfunction

	task conv_chk(input logic [2:0] m);
		@(posedge clock_i);
		mode <= m;
		conv <= 1'b1;
		@(posedge clock_i);
		conv <= 1'b0;
		#1;
		calc(m[2], m[1], m[0]);
		chk(acore_delay_o, ad);
		chk(bcore_delay_o, bd);
		chk(acore_offset_o, ao);
		chk({acore_delay_en_o, bcore_delay_en_o, acore_offset_en_o},
			{aen, ben, oen});
	endtask

	task end_sim;
		if (fails == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		void'($urandom(32'he2a1));
		for (int i = 0; i < 6; i++)
			rv[i] = (i < 3) ? {8'h00, 8'($urandom)} : 16'($urandom);
		repeat (10) @(posedge clock_i);
		rst_n_i <= 1'b1;
		@(posedge clock_i);
		fv <= 1'b1;
		chk({acore_delay_o, bcore_delay_o, acore_offset_o}, 0);
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, IDX[i], 32'h0);
			chk(rd, {16'h0000, rv[i]});
		end
		repeat (3) begin
			for (int i = 0; i < 6; i++) begin
				d = $urandom;
				rv[i] = (i < 3) ? {8'h00, d[7:0]} : d[15:0];
				apb(1'b1, IDX[i], d);
				apb(1'b0, IDX[i], 32'h0);
				chk({err, rd}, {1'b0, 16'h0000, rv[i]});
			end
			// Gap index must not alias onto its neighbours
			apb(1'b1, 12'h316, d);
			chk(err, 1'b1);
			apb(1'b0, 12'h316, 32'h0);
			chk({err, rd}, {1'b1, 32'h0});
			for (int m = 0; m < 8; m++)
				conv_chk(3'(m));
		end
		end_sim;
	end

	initial begin
		#20000;
		fails++;
		end_sim;
	end
endmodule
